// ===== board_pin_model.sv
// Board devices driving the general-purpose input pins
module board_pin_model (
  input  wire        core_clk,
  input  wire [21:0] level,
  output reg  [21:0] gpiPin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial gpiPin = 22'h3FFFFF;
  // Levels move just after an edge, like a synchronous source
  always @(posedge core_clk) gpiPin <= level;
endmodule // board_pin_model

// ===== gp_function_map.v
// Decodes configuration bits into per-pin alternate-function selects
`include "gp_pin_mux_regs.vh"

module gp_function_map (
  input  wire [31:0] general_configuration,
  input  wire [15:0] xbusCfg,
  output reg  [21:0] gpiAltSel,
  output reg  [30:0] gpoAltSel
);

  wire extIntc;

  assign extIntc = xbusCfg[`XB_EXT_INTC];

  always @* begin
    gpiAltSel = 22'h000000;
    gpoAltSel = 31'h00000000;
    // Cleared bit means full bus mode: check input and upper address take the pins
    gpiAltSel[0] = ~general_configuration[`GC_EXT_IO_BUS];
    gpoAltSel[7:1] = {7{~general_configuration[`GC_EXT_IO_BUS]}};
    gpiAltSel[4:2] = general_configuration[`GC_PCPCI_C:`GC_PCPCI_A];
    gpoAltSel[11:9] = general_configuration[`GC_PCPCI_C:`GC_PCPCI_A];
    gpiAltSel[5] = extIntc;
    gpoAltSel[14:12] = {3{extIntc}};
    gpoAltSel[29] = extIntc;
    gpiAltSel[6] = general_configuration[`GC_CLOCK_INT];
    gpiAltSel[7] = general_configuration[`GC_SERIAL_INT];
    gpiAltSel[8] = general_configuration[`GC_THERMAL];
    gpiAltSel[9] = general_configuration[`GC_BATTERY_LOW];
    gpiAltSel[10] = general_configuration[`GC_LID];
    gpiAltSel[11] = general_configuration[`GC_MGMT_ALERT];
    gpiAltSel[12] = general_configuration[`GC_RING];
    gpoAltSel[16:15] = {2{general_configuration[`GC_SUSPEND_BC]}};
    gpoAltSel[17] = general_configuration[`GC_CPU_STOP];
    gpoAltSel[18] = general_configuration[`GC_PCI_STOP];
    gpoAltSel[19] = general_configuration[`GC_CACHE_SLEEP];
    gpoAltSel[20] = general_configuration[`GC_SUSPEND_STATUS_ONE_N];
    gpoAltSel[21] = general_configuration[`GC_SUSPEND_STATUS_TWO_N];
    gpoAltSel[23:22] = {2{general_configuration[`GC_TRANSCEIVER]}};
    gpoAltSel[24] = general_configuration[`GC_EXT_CLOCK_CS];
    gpoAltSel[25] = general_configuration[`GC_EXT_CLOCK_ALE];
    gpoAltSel[26] = general_configuration[`GC_KEYBOARD_CS];
  end

endmodule // gp_function_map

// ===== gp_pin_mux_and_io_regs.v
// General-purpose input/output pins, their function multiplexing and registers
`include "gp_pin_mux_regs.vh"

module gp_pin_mux_and_io_regs #(
  parameter GPI_WIDTH = `GPI_COUNT,
  parameter GPO_WIDTH = `GPO_COUNT
) (
  input  wire                 core_clk,
  input  wire                 reset_n,
  // Power-management I/O space access, offset from the I/O base
  input  wire [7:0]           ioAddr,
  input  wire                 ioWrEn,
  input  wire                 ioRdEn,
  input  wire [3:0]           ioByteEn,
  input  wire [31:0]          ioWrData,
  output reg  [31:0]          ioRdData_ff,
  output reg                  ioRdValid_ff,
  // Configuration space access
  input  wire [7:0]           cfgAddr,
  input  wire                 cfgWrEn,
  input  wire                 cfgRdEn,
  input  wire [3:0]           cfgByteEn,
  input  wire [31:0]          cfgWrData,
  output reg  [31:0]          cfgRdData_ff,
  output reg                  cfgRdValid_ff,
  // Pins
  input  wire [GPI_WIDTH-1:0] gpiPin,
  output reg  [GPO_WIDTH-1:0] gpoPin_ff,
  input  wire                 corePowerGood,
  // Alternate function side
  input  wire [GPO_WIDTH-1:0] altOutValue,
  output reg  [GPI_WIDTH-1:0] altInLevel_ff,
  output wire [GPI_WIDTH-1:0] gpiAltSel,
  output wire [GPO_WIDTH-1:0] gpoAltSel,
  output wire                 pmInputOneActive,
  output wire                 extIntcMode
);

  reg  [GPI_WIDTH-1:0] inputLevel_ff;
  reg  [GPO_WIDTH-1:0] outputDrive_ff;
  reg  [31:0]          general_configuration_ff;
  reg  [15:0]          xbusCfg_ff;
  reg  [GPO_WIDTH-1:0] nxt_outputDrive;
  reg  [31:0]          nxt_general_configuration;
  reg  [15:0]          nxt_xbusCfg;
  reg  [31:0]          nxt_ioRdData;
  reg  [31:0]          nxt_cfgRdData;
  reg  [31:0]          mergedDrive;
  reg  [31:0]          mergedXbus;
  wire [GPO_WIDTH-1:0] pinValue;
  wire [GPI_WIDTH-1:0] altMaskedIn;

  // Byte-lane merge of write data into an old value
  function [31:0] mergeBytes;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  byteEn;
    integer      i;
    begin
      mergeBytes = oldVal;
      for (i = 0; i < 4; i = i + 1) begin
        if (byteEn[i]) begin
          mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
        end
      end
    end
  endfunction

  gp_function_map uMap (
    .general_configuration    (general_configuration_ff),
    .xbusCfg   (xbusCfg_ff),
    .gpiAltSel (gpiAltSel),
    .gpoAltSel (gpoAltSel)
  );

  assign extIntcMode = xbusCfg_ff[`XB_EXT_INTC];

  // Input 1 is never multiplexed; low level means event to power management
  assign pmInputOneActive = ~inputLevel_ff[1];

  // Register write paths
  always @* begin
    nxt_outputDrive = outputDrive_ff;
    nxt_general_configuration = general_configuration_ff;
    nxt_xbusCfg = xbusCfg_ff;
    mergedDrive = mergeBytes({1'b0, outputDrive_ff}, ioWrData, ioByteEn);
    mergedXbus = mergeBytes({16'h0000, xbusCfg_ff}, cfgWrData, cfgByteEn);
    // Stored even when the pin is in alternate use
    if (ioWrEn && ioAddr == `OUTPUT_PIN_DRIVE_OFS) begin
      nxt_outputDrive = mergedDrive[GPO_WIDTH-1:0];
    end
    if (cfgWrEn && cfgAddr == `GENERAL_CONFIGURATION_OFS) begin
      nxt_general_configuration = mergeBytes(general_configuration_ff, cfgWrData, cfgByteEn);
    end
    if (cfgWrEn && cfgAddr == `XBUS_CHIP_SELECT_CFG_OFS) begin
      nxt_xbusCfg = mergedXbus[15:0];
    end
  end

  // Read decode; unmapped offsets return zero
  always @* begin
    nxt_ioRdData = 32'h00000000;
    case (ioAddr)
      `INPUT_PIN_LEVEL_OFS: begin
        nxt_ioRdData[GPI_WIDTH-1:0] = inputLevel_ff;
      end
      `OUTPUT_PIN_DRIVE_OFS: begin
        nxt_ioRdData[GPO_WIDTH-1:0] = outputDrive_ff;
      end
      default: begin
        nxt_ioRdData = 32'h00000000;
      end
    endcase
    nxt_cfgRdData = 32'h00000000;
    case (cfgAddr)
      `GENERAL_CONFIGURATION_OFS: begin
        nxt_cfgRdData = general_configuration_ff;
      end
      `XBUS_CHIP_SELECT_CFG_OFS: begin
        nxt_cfgRdData[15:0] = xbusCfg_ff;
      end
      default: begin
        nxt_cfgRdData = 32'h00000000;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      outputDrive_ff <= `OUTPUT_PIN_DRIVE_RST;
      general_configuration_ff <= `GENERAL_CONFIGURATION_RST;
      xbusCfg_ff <= `XBUS_CHIP_SELECT_CFG_RST;
      inputLevel_ff <= {GPI_WIDTH{1'b1}};
      ioRdData_ff <= 32'h00000000;
      ioRdValid_ff <= 1'b0;
      cfgRdData_ff <= 32'h00000000;
      cfgRdValid_ff <= 1'b0;
    end else begin
      outputDrive_ff <= nxt_outputDrive;
      general_configuration_ff <= nxt_general_configuration;
      xbusCfg_ff <= nxt_xbusCfg;
      inputLevel_ff <= gpiPin;
      ioRdValid_ff <= ioRdEn;
      cfgRdValid_ff <= cfgRdEn;
      if (ioRdEn) begin
        ioRdData_ff <= nxt_ioRdData;
      end
      if (cfgRdEn) begin
        cfgRdData_ff <= nxt_cfgRdData;
      end
    end
  end

  // Per-pin output selection
  genvar g;
  generate
    for (g = 0; g < GPO_WIDTH; g = g + 1) begin : gOut
      if (g == `GPO_CORE_LOSS_LOW) begin : gLow
        // Dedicated output; forced low when core power goes away
        assign pinValue[g] = corePowerGood & outputDrive_ff[g];
      end else begin : gMux
        // Alternate source includes active-low level interrupt-9 on output 29
        assign pinValue[g] = gpoAltSel[g] ? altOutValue[g]
                                          : outputDrive_ff[g];
      end
    end
    for (g = 0; g < GPI_WIDTH; g = g + 1) begin : gIn
      // Alternate consumers see an idle high level when not assigned
      assign altMaskedIn[g] = gpiAltSel[g] ? inputLevel_ff[g] : 1'b1;
    end
  endgenerate

  always @(posedge core_clk) begin
    if (!reset_n) begin
      // General-purpose pins at register reset, alternate pins idle high
      gpoPin_ff <= `OUTPUT_PIN_DRIVE_RST | `GPO_ALT_IDLE_RST;
      altInLevel_ff <= {GPI_WIDTH{1'b1}};
    end else begin
      gpoPin_ff <= pinValue;
      altInLevel_ff <= altMaskedIn;
    end
  end

endmodule // gp_pin_mux_and_io_regs

// ===== gp_pin_mux_checker_properties.sv
// Timing and mapping checks on the general-purpose pin block ports
module gp_pin_mux_checker #(
  parameter GPI_WIDTH = 22,
  parameter GPO_WIDTH = 31
) (
  input wire                 core_clk,
  input wire                 reset_n,
  input wire [7:0]           ioAddr,
  input wire                 ioWrEn,
  input wire                 ioRdEn,
  input wire [31:0]          ioWrData,
  input wire [31:0]          ioRdData_ff,
  input wire                 ioRdValid_ff,
  input wire [7:0]           cfgAddr,
  input wire                 cfgWrEn,
  input wire [31:0]          cfgWrData,
  input wire [GPI_WIDTH-1:0] gpiPin,
  input wire [GPO_WIDTH-1:0] gpoPin_ff,
  input wire                 corePowerGood,
  input wire [GPO_WIDTH-1:0] altOutValue,
  input wire [GPI_WIDTH-1:0] altInLevel_ff,
  input wire [GPI_WIDTH-1:0] gpiAltSel,
  input wire [GPO_WIDTH-1:0] gpoAltSel,
  input wire                 pmInputOneActive,
  input wire                 extIntcMode
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [31:0] wd_ff;
  // Configuration write data bus of the previous cycle, sampled whether or not cfgWrEn is set
  always @(posedge core_clk) wd_ff <= cfgWrData;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  rd_valid_a: assert property (ioRdEn |=> ioRdValid_ff)
    else $error("read gave no valid");
  input_read_a: assert property (ioRdEn && ioAddr == 8'h30 && $stable(gpiPin)
    |=> ioRdData_ff == {10'h0, $past(gpiPin)}) else $error("input read wrong");
  gpo_drive_a: assert property (ioWrEn && ioAddr == 8'h34 && corePowerGood
    |=> ##1 (gpoPin_ff & 31'h58000101) == ($past(ioWrData[30:0], 2) & 31'h58000101))
    else $error("dedicated output wrong");
  alt_drive_a: assert property ($past(reset_n) && $past(corePowerGood)
    |-> ((gpoPin_ff ^ $past(altOutValue)) & $past(gpoAltSel)) == 31'h0)
    else $error("alternate output wrong");
  power_loss_a: assert property (!corePowerGood |=> !gpoPin_ff[8])
    else $error("output 8 not low");
  gen_map_a: assert property (cfgWrEn && cfgAddr == 8'hB0
    |=> gpoAltSel[26:15] == {wd_ff[31:28], wd_ff[28], wd_ff[22:17], wd_ff[17]}
    && gpoAltSel[11:9] == wd_ff[10:8] && gpoAltSel[7:1] == {7{~wd_ff[0]}})
    else $error("output mapping wrong");
  gpi_map_a: assert property (cfgWrEn && cfgAddr == 8'hB0
    |=> gpiAltSel[12:7] == {wd_ff[27], wd_ff[15], wd_ff[25:23], wd_ff[16]}
    && gpiAltSel[4:2] == wd_ff[10:8] && gpiAltSel[0] == ~wd_ff[0]
    && (extIntcMode || gpiAltSel[6] == wd_ff[14])) else $error("input mapping wrong");
  ext_intc_a: assert property (cfgWrEn && cfgAddr == 8'h4C |=> extIntcMode == wd_ff[8]
    && gpiAltSel[5] == wd_ff[8] && gpoAltSel[14:12] == {3{wd_ff[8]}}
    && gpoAltSel[29] == wd_ff[8]) else $error("controller mapping wrong");
  fixed_pins_a: assert property (gpiAltSel[1] == 1'b0 && gpiAltSel[21:13] == 9'h0
    && (gpoAltSel & 31'h58000101) == 31'h0) else $error("dedicated pin muxed");
  in_level_a: assert property ($past(reset_n) && $past(reset_n, 2)
    && $past(gpiPin) == $past(gpiPin, 2) && $past(gpiAltSel) == $past(gpiAltSel, 2)
    |-> altInLevel_ff == ($past(gpiPin) | ~$past(gpiAltSel))
    && pmInputOneActive == ~$past(gpiPin[1])) else $error("input level wrong");
endmodule // gp_pin_mux_checker

bind gp_pin_mux_and_io_regs gp_pin_mux_checker #(.GPI_WIDTH(GPI_WIDTH), .GPO_WIDTH(GPO_WIDTH))
  i_checker (.core_clk(core_clk), .reset_n(reset_n), .ioAddr(ioAddr), .ioWrEn(ioWrEn),
  .ioRdEn(ioRdEn), .ioWrData(ioWrData), .ioRdData_ff(ioRdData_ff), .ioRdValid_ff(ioRdValid_ff),
  .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData), .gpiPin(gpiPin),
  .gpoPin_ff(gpoPin_ff), .corePowerGood(corePowerGood), .altOutValue(altOutValue),
  .altInLevel_ff(altInLevel_ff), .gpiAltSel(gpiAltSel), .gpoAltSel(gpoAltSel),
  .pmInputOneActive(pmInputOneActive), .extIntcMode(extIntcMode));

// ===== gp_pin_mux_regs.vh
// Register offsets, field positions and reset values of the general-purpose pin block
`ifndef GP_PIN_MUX_REGS_VH
`define GP_PIN_MUX_REGS_VH

// Power-management I/O space, offsets from the I/O base
`define INPUT_PIN_LEVEL_OFS      8'h30
`define OUTPUT_PIN_DRIVE_OFS     8'h34

// Configuration space offsets
`define GENERAL_CONFIGURATION_OFS 8'hB0
`define XBUS_CHIP_SELECT_CFG_OFS  8'h4C

// Widths
`define GPI_COUNT                22
`define GPO_COUNT                31

// Reset values
`define OUTPUT_PIN_DRIVE_RST     31'h00000000
`define GENERAL_CONFIGURATION_RST 32'hFBFE8001
`define GPO_ALT_IDLE_RST         31'h07FF8000
`define XBUS_CHIP_SELECT_CFG_RST 16'h0000

// General configuration field positions
`define GC_EXT_IO_BUS            0
`define GC_PCPCI_A               8
`define GC_PCPCI_B               9
`define GC_PCPCI_C               10
`define GC_CLOCK_INT             14
`define GC_MGMT_ALERT            15
`define GC_SERIAL_INT            16
`define GC_SUSPEND_BC            17
`define GC_CPU_STOP              18
`define GC_PCI_STOP              19
`define GC_CACHE_SLEEP           20
`define GC_SUSPEND_STATUS_ONE_N             21
`define GC_SUSPEND_STATUS_TWO_N             22
`define GC_THERMAL               23
`define GC_BATTERY_LOW           24
`define GC_LID                   25
`define GC_RING                  27
`define GC_TRANSCEIVER           28
`define GC_EXT_CLOCK_CS          29
`define GC_EXT_CLOCK_ALE         30
`define GC_KEYBOARD_CS           31

// X-bus chip select field positions
`define XB_EXT_INTC              8

// Output that stays low when core power is gone
`define GPO_CORE_LOSS_LOW        8

`endif

// ===== tb_gp_pin_mux_and_io_regs.sv
// Self-checking testbench of the general-purpose pin block
module tb_gp_pin_mux_and_io_regs;
  timeunit 1ns;
  timeprecision 1ps;
  reg         core_clk = 1'b0;
  reg         reset_n = 1'b0;
  reg         corePowerGood = 1'b1;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wrData = 32'h0;
  reg         ioWrEn = 1'b0, ioRdEn = 1'b0, cfgWrEn = 1'b0, cfgRdEn = 1'b0;
  reg  [30:0] altOut = 31'h2AAA5555;
  reg  [21:0] level = 22'h3FFFFF;
  wire [31:0] ioRdData, cfgRdData;
  wire        ioRdValid, cfgRdValid, pmIn1, extIntc;
  wire [21:0] gpiPin, gpiAltSel, altIn;
  wire [30:0] gpoPin, gpoAltSel;
  int         n_errors = 0;
  int         compares = 0;

  always #2 core_clk = ~core_clk;
  board_pin_model i_board (.core_clk(core_clk), .level(level), .gpiPin(gpiPin));
  gp_pin_mux_and_io_regs i_dut (.core_clk(core_clk), .reset_n(reset_n), .ioAddr(addr),
    .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .ioByteEn(4'hF), .ioWrData(wrData),
    .ioRdData_ff(ioRdData), .ioRdValid_ff(ioRdValid), .cfgAddr(addr), .cfgWrEn(cfgWrEn),
    .cfgRdEn(cfgRdEn), .cfgByteEn(4'hF), .cfgWrData(wrData), .cfgRdData_ff(cfgRdData),
    .cfgRdValid_ff(cfgRdValid), .gpiPin(gpiPin), .gpoPin_ff(gpoPin),
    .corePowerGood(corePowerGood), .altOutValue(altOut), .altInLevel_ff(altIn),
    .gpiAltSel(gpiAltSel), .gpoAltSel(gpoAltSel), .pmInputOneActive(pmIn1),
    .extIntcMode(extIntc));

  task automatic finish_test;
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input [31:0] exp, input [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input bit cfg, input [7:0] a, input [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wrData <= d;
    {cfgWrEn, ioWrEn} <= cfg ? 2'b10 : 2'b01;
    @(posedge core_clk);
    {cfgWrEn, ioWrEn} <= 2'b00;
    step(2);
  endtask
  task automatic rd(input bit cfg, input [7:0] a, input [31:0] exp, input string name);
    int i;
    @(posedge core_clk);
    addr <= a;
    {cfgRdEn, ioRdEn} <= cfg ? 2'b10 : 2'b01;
    @(posedge core_clk);
    {cfgRdEn, ioRdEn} <= 2'b00;
    #1;
    for (i = 0; i < 4 && (cfg ? cfgRdValid : ioRdValid) !== 1'b1; i++) step(1);
    chk("read valid", 32'h1, {31'h0, cfg ? cfgRdValid : ioRdValid});
    chk(name, exp, cfg ? cfgRdData : ioRdData);
  endtask

  task automatic resetDefaults;
    chk("output alt select", 32'h07FF8000, {1'b0, gpoAltSel});
    chk("input alt select", 32'h00001F00, {10'h0, gpiAltSel});
    repeat (4) begin
      step(1);
      chk("general pins", 32'h0, {1'b0, gpoPin & ~gpoAltSel});
      chk("alternate pins", {1'b0, altOut & gpoAltSel}, {1'b0, gpoPin & gpoAltSel});
    end
  endtask
  task automatic inputRead;
    @(posedge core_clk) level <= 22'h2A5C3D;
    step(3);
    rd(0, 8'h30, 32'h002A5C3D, "input level");
    chk("input one active", 32'h1, {31'h0, pmIn1});
    chk("alt input level", 32'h003FFCFF, {10'h0, altIn});
    wr(0, 8'h30, 32'h0);
    rd(0, 8'h30, 32'h002A5C3D, "input level kept");
    rd(0, 8'h38, 32'h0, "unmapped read");
  endtask
  task automatic outputWrite;
    wr(1, 8'hB0, 32'h00000001);
    wr(0, 8'h34, 32'h5A5AA5A5);
    chk("output pins", 32'h5A5AA5A5, {1'b0, gpoPin});
    rd(0, 8'h34, 32'h5A5AA5A5, "output register");
    rd(1, 8'hB0, 32'h00000001, "configuration");
  endtask
  task automatic altThenBack;
    wr(1, 8'hB0, 32'hFFFFFFFE);
    wr(0, 8'h34, 32'h3C3CC3C3);
    chk("alt mux pins", {1'b0, (altOut & 31'h07FF8EFE) | (31'h3C3CC3C3 & ~31'h07FF8EFE)},
      {1'b0, gpoPin});
    chk("input alt all", 32'h00001FDD, {10'h0, gpiAltSel});
    wr(1, 8'hB0, 32'h00000001);
    chk("stored pins", 32'h3C3CC3C3, {1'b0, gpoPin});
  endtask
  task automatic extIntcMode;
    wr(1, 8'h4C, 32'h00000100);
    chk("controller mode", 32'h1, {31'h0, extIntc});
    chk("controller pins", {1'b0, altOut & 31'h20007000}, {1'b0, gpoPin & 31'h20007000});
    @(posedge core_clk) altOut[29] <= ~altOut[29];
    step(2);
    chk("int9 level", {31'h0, altOut[29]}, {31'h0, gpoPin[29]});
    wr(1, 8'h4C, 32'h0);
    chk("int9 released", 32'h1, {31'h0, gpoPin[29]});
  endtask
  task automatic powerLoss;
    wr(0, 8'h34, 32'h00000100);
    @(posedge core_clk) corePowerGood <= 1'b0;
    step(2);
    chk("output 8 power loss", 32'h0, {31'h0, gpoPin[8]});
    @(posedge core_clk) corePowerGood <= 1'b1;
    step(2);
    chk("output 8 restored", 32'h1, {31'h0, gpoPin[8]});
  endtask

  initial begin
    repeat (3000) @(posedge core_clk);
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    resetDefaults;
    inputRead;
    outputWrite;
    altThenBack;
    extIntcMode;
    powerLoss;
    @(posedge core_clk) reset_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    resetDefaults;
    finish_test;
  end
endmodule // tb_gp_pin_mux_and_io_regs
